/* File: hw/bsct_alu_if.sv */
// carrier between the sequencer and the bit operation unit
interface bsct_alu_if;
    import bsct_pkg::*;

    bsct_op_t op;
    logic [BSCT_DATA_W-1:0] operand;
    logic [BSCT_BIT_W-1:0] bit_idx;
    logic [BSCT_DATA_W-1:0] result;
    logic write;
    logic skip;

    modport alu (
        input op,
        input operand,
        input bit_idx,
        output result,
        output write,
        output skip
    );

    modport core (
        output op,
        output operand,
        output bit_idx,
        input result,
        input write,
        input skip
    );
endinterface

/* File: hw/bsct_bit_alu.sv */
// single-bit clear, set and test unit
module bsct_bit_alu
    import bsct_pkg::*;
(
    bsct_alu_if.alu p
);

    // ----------------------------------------
    // bit operation
    // ----------------------------------------
    logic [BSCT_DATA_W-1:0] mask;
    logic tested;

    always_comb begin
        mask = BSCT_BIT0_MASK << p.bit_idx;
        tested = p.operand[p.bit_idx];
        p.result = p.operand;
        p.write = 1'b0;
        p.skip = 1'b0;
        unique case (p.op)
            bit_clear_op: begin
                p.result = p.operand & ~mask;
                p.write = 1'b1;
            end
            bit_set_op: begin
                p.result = p.operand | mask;
                p.write = 1'b1;
            end
            skip_if_bit_clear_op: begin
                p.skip = ~tested;
            end
            skip_if_bit_set_op: begin
                p.skip = tested;
            end
        endcase
    end

endmodule

/* File: hw/bsct_exec.sv */
// execution of the four single-bit instructions
module bsct_exec
    import bsct_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic issue_valid,
    input wire logic issue_is_bit,
    input wire bsct_op_t issue_op,
    input wire logic [BSCT_ADDR_W-1:0] issue_addr,
    input wire logic [BSCT_BIT_W-1:0] issue_bit,
    output logic [BSCT_ADDR_W-1:0] rf_raddr,
    input wire logic [BSCT_DATA_W-1:0] rf_rdata,
    output logic rf_we,
    output logic [BSCT_ADDR_W-1:0] rf_waddr,
    output logic [BSCT_DATA_W-1:0] rf_wdata,
    output logic retire,
    output logic retire_nop,
    output logic skip_pending
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    // one bit index value per data bit
    if (BSCT_DATA_W != (1 << BSCT_BIT_W)) begin : g_bad_bit_w
        $error("bit index width does not match data width");
    end
    // full register address range of the operand
    if (BSCT_ADDR_W != 8) begin : g_bad_addr_w
        $error("register address must be eight bits");
    end
    // sequencer codes one-hot
    if ($countones(bsct_st_exec) != 1 || $countones(bsct_st_discard) != 1) begin : g_bad_state
        $error("sequencer state codes must be one-hot");
    end
    // one flip-flop per sequencer state
    if ($bits(bsct_state_t) != 2) begin : g_bad_state_w
        $error("sequencer state needs one bit per state");
    end
    // mask source is bit 0 alone
    if (BSCT_BIT0_MASK != 8'h01) begin : g_bad_mask
        $error("bit mask seed must be bit 0");
    end
    // four operations in the op code
    if ($bits(bsct_op_t) != 2) begin : g_bad_op_w
        $error("operation code must be two bits");
    end
    // idle after reset, no discard owed
    if (BSCT_RST_STATE != bsct_st_exec) begin : g_bad_rst
        $error("reset state must be the execute state");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        // sequencer position
        bsct_state_t state;
        // write strobe and its target
        logic we;
        logic [BSCT_ADDR_W-1:0] waddr;
        logic [BSCT_DATA_W-1:0] wdata;
        // retire pulses
        logic retire;
        logic nop;
    } bsct_regs_t;

    // ----------------------------------------
    // value after reset
    // ----------------------------------------
    // no strobe, no pulse, no discard owed
    localparam bsct_regs_t BSCT_RST_REGS = '{
        state: BSCT_RST_STATE,
        we: 1'b0,
        waddr: BSCT_RST_ADDR,
        wdata: BSCT_RST_DATA,
        retire: 1'b0,
        nop: 1'b0
    };

    bsct_regs_t q;
    bsct_regs_t next_q;

    // ----------------------------------------
    // bit operation unit
    // ----------------------------------------
    bsct_alu_if alu_bus ();

    bsct_bit_alu u_alu (
        .p(alu_bus.alu)
    );

    // ----------------------------------------
    // operand fetch
    // ----------------------------------------
    assign alu_bus.op = issue_op;
    assign alu_bus.bit_idx = issue_bit;

    // ----------------------------------------
    // write forwarding
    // ----------------------------------------
    // pending write not yet in the register file
    wire [BSCT_ADDR_W-1:0] addr_eq;
    wire [BSCT_DATA_W-1:0] operand_sel;
    logic fwd_hit;

    for (genvar i = 0; i < BSCT_ADDR_W; i++) begin : g_addr_eq
        assign addr_eq[i] = (q.waddr[i] == issue_addr[i]);
    end

    assign fwd_hit = q.we && (&addr_eq);

    for (genvar j = 0; j < BSCT_DATA_W; j++) begin : g_operand
        assign operand_sel[j] = fwd_hit ? q.wdata[j] : rf_rdata[j];
    end

    assign alu_bus.operand = operand_sel;

    // ----------------------------------------
    // slot decode
    // ----------------------------------------
    logic in_exec;
    logic in_discard;
    logic bit_fire;
    logic wr_fire;
    logic skip_fire;
    logic discard_fire;

    assign in_exec = (q.state == bsct_st_exec);
    assign in_discard = (q.state == bsct_st_discard);
    // a bit op runs only when no discard is owed
    assign bit_fire = in_exec && issue_valid && issue_is_bit;
    // clear and set write back, tests never do
    assign wr_fire = bit_fire && alu_bus.write;

    // ----------------------------------------
    // skip bookkeeping
    // ----------------------------------------
    // a test whose bit matched owes one discarded slot
    assign skip_fire = bit_fire && alu_bus.skip;
    // any valid slot pays off an owed discard
    assign discard_fire = in_discard && issue_valid;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        next_q = q;
        // strobes last one cycle
        next_q.we = 1'b0;
        next_q.retire = 1'b0;
        next_q.nop = 1'b0;
        unique case (q.state)
            bsct_st_exec: begin
                // every bit op retires with a pulse one cycle later
                if (bit_fire) begin
                    next_q.retire = 1'b1;
                end
                // clear and set land one cycle later
                if (wr_fire) begin
                    next_q.we = 1'b1;
                    next_q.waddr = issue_addr;
                    next_q.wdata = alu_bus.result;
                end
                // tested bit matched, next slot is owed
                if (skip_fire) begin
                    next_q.state = bsct_st_discard;
                end
            end
            bsct_st_discard: begin
                // the owed slot retires as a nop, nothing written
                if (discard_fire) begin
                    next_q.nop = 1'b1;
                    next_q.state = bsct_st_exec;
                end
            end
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q <= BSCT_RST_REGS;
        end else begin
            q <= next_q;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    assign rf_raddr = issue_addr;

    // ----------------------------------------
    // write port
    // ----------------------------------------
    assign rf_we = q.we;
    assign rf_waddr = q.waddr;
    assign rf_wdata = q.wdata;

    // ----------------------------------------
    // retire flags
    // ----------------------------------------
    assign retire = q.retire;
    assign retire_nop = q.nop;

    // ----------------------------------------
    // skip status
    // ----------------------------------------
    assign skip_pending = in_discard;

endmodule

/* File: hw/bsct_pkg.sv */
// shared types and constants of the bit set/clear/test execution block
package bsct_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int BSCT_ADDR_W = 8;
    localparam int BSCT_DATA_W = 8;
    localparam int BSCT_BIT_W = 3;

    // ----------------------------------------
    // operations
    // ----------------------------------------
    typedef enum logic [1:0] {
        bit_clear_op = 2'h0,
        bit_set_op = 2'h1,
        skip_if_bit_clear_op = 2'h2,
        skip_if_bit_set_op = 2'h3
    } bsct_op_t;

    // ----------------------------------------
    // sequencer states, one-hot
    // ----------------------------------------
    typedef enum logic [1:0] {
        bsct_st_exec = 2'h1,
        bsct_st_discard = 2'h2
    } bsct_state_t;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam bsct_state_t BSCT_RST_STATE = bsct_st_exec;
    localparam logic [BSCT_ADDR_W-1:0] BSCT_RST_ADDR = 8'h00;
    localparam logic [BSCT_DATA_W-1:0] BSCT_RST_DATA = 8'h00;
    localparam logic [BSCT_DATA_W-1:0] BSCT_BIT0_MASK = 8'h01;

endpackage

/* File: test/bsct_exec_props.sv */
// checker for the bit set/clear/test execution block
module bsct_exec_props import bsct_pkg::*; (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic issue_valid,
    input wire logic issue_is_bit,
    input wire bsct_op_t issue_op,
    input wire logic [7:0] issue_addr,
    input wire logic [7:0] rf_raddr,
    input wire logic [7:0] rf_rdata,
    input wire logic [7:0] rf_waddr,
    input wire logic [7:0] rf_wdata,
    input wire logic [2:0] issue_bit,
    input wire logic rf_we,
    input wire logic retire,
    input wire logic retire_nop,
    input wire logic skip_pending
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    wire ex = issue_valid && issue_is_bit && !skip_pending;
    wire [7:0] d = (rf_we && rf_waddr == issue_addr) ? rf_wdata : rf_rdata;
    wire [7:0] m = 8'h01 << issue_bit;
    wire tb = d[issue_bit];
    a_clear_write: assert property (ex && issue_op == bit_clear_op |=> rf_we && rf_wdata == ($past(d) & ~$past(m))
        && rf_waddr == $past(issue_addr)) else $error("clear result wrong");
    a_set_write: assert property (ex && issue_op == bit_set_op |=> rf_we && rf_wdata == ($past(d) | $past(m)))
        else $error("set result wrong");
    a_skip_clear: assert property (ex && issue_op == skip_if_bit_clear_op |=> !rf_we && skip_pending == !$past(tb))
        else $error("skip on clear wrong");
    a_skip_set: assert property (ex && issue_op == skip_if_bit_set_op |=> !rf_we && skip_pending == $past(tb))
        else $error("skip on set wrong");
    a_nop_slot: assert property (skip_pending && issue_valid |=> retire_nop && !retire && !rf_we && !skip_pending)
        else $error("discarded slot wrong");
    a_resume_next: assert property (ex |=> retire && !retire_nop)
        else $error("slot after test not run");
    a_read_addr: assert property (rf_raddr == issue_addr)
        else $error("read address wrong");
    c_skip: cover property (ex && issue_op == skip_if_bit_set_op && tb);
    c_nop: cover property (retire_nop);
    c_fwd: cover property (ex && rf_we && rf_waddr == issue_addr);
endmodule

/* File: test/bsct_rf_model.sv */
// register file model: combinational read, write at the clock edge
module bsct_rf_model (
    input wire logic clk_sys,
    input wire logic [7:0] raddr,
    output logic [7:0] rdata,
    input wire logic we,
    input wire logic [7:0] waddr,
    input wire logic [7:0] wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [256];
    assign rdata = mem[raddr];
    always @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
endmodule

/* File: test/tb.sv */
// bench: issues bit ops, checks register contents and discards
module tb import bsct_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, arst_n = 0, v = 0, isb = 0;
    bsct_op_t op = bit_clear_op;
    logic [7:0] a = 8'h00;
    logic [2:0] b = 3'h0;
    wire [7:0] ra, rd, wa, wd;
    wire we, ret, nop, sp;
    int err_count = 0, n_compared = 0, cyc = 0;
    bsct_exec i_dut (.clk_sys, .arst_n, .issue_valid(v), .issue_is_bit(isb), .issue_op(op), .issue_addr(a),
        .issue_bit(b), .rf_raddr(ra), .rf_rdata(rd), .rf_we(we), .rf_waddr(wa), .rf_wdata(wd), .retire(ret),
        .retire_nop(nop), .skip_pending(sp));
    bsct_rf_model i_rf (.clk_sys, .raddr(ra), .rdata(rd), .we, .waddr(wa), .wdata(wd));
    initial forever #50 clk_sys = ~clk_sys;
    task chk(string n, logic [7:0] s, logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task slot(logic vv, bsct_op_t o, logic [7:0] ad, logic [2:0] bi, logic ib = 1'b1);
        @(negedge clk_sys);
        v = vv;
        isb = ib;
        op = o;
        a = ad;
        b = bi;
    endtask
    task t_clear_set;
        i_rf.mem[8'hff] = 8'h8d;
        slot(1, bit_clear_op, 8'hff, 2);
        slot(1, bit_set_op, 8'hff, 1);
        chk("wdata clear", wd, 8'h89);
        chk("retire clear", {7'h00, ret}, 8'h01);
        slot(1, bit_set_op, 8'hff, 2);
        chk("wdata set", wd, 8'h8b);
        chk("waddr", wa, 8'hff);
        chk("raddr", ra, 8'hff);
        slot(0, bit_clear_op, 8'h00, 0);
        slot(0, bit_clear_op, 8'h00, 0);
        chk("reg ff", i_rf.mem[8'hff], 8'h8f);
        $display("test clear_set done");
    endtask
    task t_skip;
        logic s;
        i_rf.mem[8'h10] = 8'h04;
        for (int k = 0; k < 4; k++) begin
            s = (k[0] != k[1]);
            i_rf.mem[8'h20] = 8'h00;
            slot(1, k[0] ? skip_if_bit_set_op : skip_if_bit_clear_op, 8'h10, k[1] ? 3'h3 : 3'h2);
            slot(1, bit_set_op, 8'h20, 0);
            chk("skip pending", {7'h00, sp}, {7'h00, s});
            chk("retire test", {7'h00, ret}, 8'h01);
            slot(1, bit_set_op, 8'h20, 1);
            chk("nop slot", {7'h00, nop}, {7'h00, s});
            chk("retire after", {7'h00, ret}, {7'h00, !s});
            slot(0, bit_clear_op, 8'h00, 0);
            slot(0, bit_clear_op, 8'h00, 0);
            chk("reg 20", i_rf.mem[8'h20], s ? 8'h02 : 8'h03);
            chk("reg 10", i_rf.mem[8'h10], 8'h04);
        end
        $display("test skip done");
    endtask
    task t_other;
        i_rf.mem[8'h30] = 8'h00;
        slot(1, bit_set_op, 8'h30, 4, 1'b0);
        slot(0, bit_clear_op, 8'h00, 0);
        chk("retire other", {7'h00, ret}, 8'h00);
        chk("we other", {7'h00, we}, 8'h00);
        slot(0, bit_clear_op, 8'h00, 0);
        chk("reg 30", i_rf.mem[8'h30], 8'h00);
        $display("test other done");
    endtask
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 2000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(negedge clk_sys);
        arst_n = 1;
        t_clear_set();
        t_skip();
        t_other();
        complete_run();
    end
endmodule
bind bsct_exec bsct_exec_props i_props (.clk_sys, .arst_n, .issue_valid, .issue_is_bit, .issue_op, .issue_addr,
    .issue_bit, .rf_raddr, .rf_rdata, .rf_we, .rf_waddr, .rf_wdata, .retire, .retire_nop, .skip_pending);
